// *** rtl/sockc_apb_slave.v ***
// apb slave front end: zero-wait-state access, registered read data
// assumes the parent decodes the index and supplies read data and a hit flag
`timescale 1ns/1ns
module sockc_apb_slave #(
	parameter AW = 16
) (
	input wire i_clk,
	input wire i_nrst,
	input wire i_ce,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [AW-1:0] i_paddr,
	input wire [31:0] i_rdata,
	input wire i_hit,
	output wire [11:0] o_index,
	output wire o_wr,
	output reg [31:0] o_prdata,
	output wire o_pready,
	output wire o_pslverr
);
	wire access;
	wire mapped;

	// misaligned addresses never hit a register
	assign o_index = i_paddr[13:2];
	assign mapped = i_hit && (i_paddr[1:0] == 2'h0) && (i_paddr[AW-1:14] == {(AW-14){1'b0}});
	// ready is held low while the clock enable freezes the block, so no write is lost
	assign access = i_psel && i_penable && i_ce;
	assign o_pready = access;
	assign o_pslverr = access && !mapped;
	assign o_wr = access && i_pwrite && mapped;

	// read data captured in the setup cycle, stable through the access phase
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_prdata <= 32'h00000000;
		else if (i_ce && i_psel && !i_penable)
			o_prdata <= mapped ? i_rdata : 32'h00000000;
	end
endmodule // sockc_apb_slave

// *** rtl/sockc_consts.vh ***
// constants for the per-socket command and event-flag block
// assumes it is included by bare name from files under rtl/
`ifndef SOCKC_CONSTS_VH
`define SOCKC_CONSTS_VH

// register indices; byte address on the bus is four times the index
`define SOCKC_IDX_MODE 12'h400
`define SOCKC_IDX_COMMAND 12'h401
`define SOCKC_IDX_FLAGS 12'h402
`define SOCKC_IDX_STATE 12'h403
`define SOCKC_IDX_TX_WR 12'h424
`define SOCKC_IDX_RX_RD 12'h428

// reset values
`define SOCKC_RST_BYTE 8'h00
`define SOCKC_RST_PTR 16'h0000

// command codes
`define SOCKC_CMD_NONE 8'h00
`define SOCKC_CMD_OPEN 8'h01
`define SOCKC_CMD_LISTEN 8'h02
`define SOCKC_CMD_CONNECT 8'h04
`define SOCKC_CMD_TEARDOWN 8'h08
`define SOCKC_CMD_CLOSE 8'h10
`define SOCKC_CMD_SEND 8'h20
`define SOCKC_CMD_SEND_MANUAL 8'h21
`define SOCKC_CMD_KEEPALIVE 8'h22
`define SOCKC_CMD_RECEIVE_DONE 8'h40

// socket state codes
`define SOCKC_ST_SHUT 8'h00
`define SOCKC_ST_TCP_INITIAL 8'h13
`define SOCKC_ST_LISTENING 8'h14
`define SOCKC_ST_SYN_SENT 8'h15
`define SOCKC_ST_ESTABLISHED 8'h17
`define SOCKC_ST_FIN_WAIT 8'h18
`define SOCKC_ST_CLOSE_WAIT 8'h1C
`define SOCKC_ST_DATAGRAM 8'h22
`define SOCKC_ST_RAW_IP 8'h32
`define SOCKC_ST_RAW_ETHERNET 8'h42

// protocol-mode field, bits 3..0 of the mode register
`define SOCKC_MODE_TCP 4'h1
`define SOCKC_MODE_UDP 4'h2
`define SOCKC_MODE_RAW_IP 4'h3
`define SOCKC_MODE_RAW_ETHERNET 4'h4
`define SOCKC_MODE_WMASK 8'hEF

// event flag bit positions
`define SOCKC_FLAG_LINK_UP 0
`define SOCKC_FLAG_LINK_DOWN 1
`define SOCKC_FLAG_RECEIVE 2
`define SOCKC_FLAG_TIMEOUT 3
`define SOCKC_FLAG_TX_DONE 4
`define SOCKC_FLAG_COUNT 5

`endif

// *** rtl/sockc_event_flags.v ***
// sticky event flags, cleared by writing one; unused upper bits read zero
// assumes set pulses and clear strobe come from logic on the same clock
`timescale 1ns/1ns
`include "sockc_consts.vh"
module sockc_event_flags (
	input wire i_clk,
	input wire i_nrst,
	input wire i_ce,
	input wire [`SOCKC_FLAG_COUNT-1:0] i_set,
	input wire i_clr_wr,
	input wire [7:0] i_clr_data,
	output wire [7:0] o_flags
);
	reg [`SOCKC_FLAG_COUNT-1:0] flag;

	genvar g;
	// one sticky bit per event; a set in the clearing cycle wins
	generate
		for (g = 0; g < `SOCKC_FLAG_COUNT; g = g + 1)
		begin : g_flag
			always @(posedge i_clk or negedge i_nrst)
			begin
				if (!i_nrst)
					flag[g] <= 1'b0;
				else if (i_ce)
				begin
					if (i_set[g])
						flag[g] <= 1'b1;
					else if (i_clr_wr && i_clr_data[g])
						flag[g] <= 1'b0; // R12
				end
			end
		end
	endgenerate

	// bits 7..5 have no storage
	assign o_flags = {3'h0, flag}; // R20
endmodule // sockc_event_flags

// *** rtl/sockc_top.v ***
// per-socket command interpreter and event flags, with an apb register port
// assumes a protocol engine on the same clock answers each request except receive-done with done or fail
//
// Behaviour
// R1: after any accepted command the command byte returns to zero by itself
// R2: open moves state to tcp initial, datagram, raw ip or raw ethernet by mode
// R3: listen, tcp only, moves the socket to the listening state
// R4: connect, tcp only, requests a connection; a failure raises timeout
// R5: teardown, tcp only, requests termination; a failure raises timeout
// R6: close sets the state to shut
// R7: close on a connected socket only changes state, no exchange with the peer
// R8: send transmits the bytes the write pointer advanced since the last send
// R9: manual-address send, udp only, uses the written hardware address, no resolution
// R10: keep-alive, tcp only, sends one byte; no answer or dead link raises timeout
// R11: receive-done frees buffer space up to the written read pointer
// R12: flags stay set until written with one; only those bits clear
// R13: flag bit 4 sets when a send completes
// R14: flag bit 3 sets on timeout in setup, teardown or transmission
// R15: flag bit 2 sets on arrival and again if data remains after receive-done
// R16: flag bit 1 sets when the peer asks to terminate or termination finishes
// R17: flag bit 0 sets when a connection is established
// R18: state codes: tcp initial 13, listening 14, udp 22, raw ip 32, raw eth 42, shut 00
// R19: mode 0100 selects raw ethernet, only on socket 0
// R20: flag bits 7..5 ignore writes and read zero
// R21: undefined or mode-invalid commands are ignored, state kept, command byte cleared
`timescale 1ns/1ns
`include "sockc_consts.vh"
module sockc_top #(
	parameter SOCKET_ID = 0,
	parameter AW = 16
) (
	input wire i_clk,
	input wire i_nrst,
	input wire i_ce,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [AW-1:0] i_paddr,
	input wire [31:0] i_pwdata,
	output wire [31:0] o_prdata,
	output wire o_pready,
	output wire o_pslverr,
	output reg o_eng_req,
	output reg [7:0] o_eng_op,
	output reg [15:0] o_tx_start,
	output reg [15:0] o_tx_len,
	output reg o_use_manual_hw,
	output reg [15:0] o_rx_rd_ptr,
	input wire i_eng_done,
	input wire i_eng_fail,
	input wire i_peer_conn,
	input wire i_peer_fin,
	input wire i_rx_arrived,
	input wire i_rx_pending
);
	localparam PH_IDLE = 2'b00;
	localparam PH_EXEC = 2'b01;
	localparam PH_WAIT = 2'b10;

	reg [1:0] phase;
	reg [1:0] next_phase;
	reg [7:0] socket_command;
	reg [7:0] socket_protocol_mode;
	reg [7:0] socket_state;
	reg [7:0] next_state;
	reg [15:0] tx_write_pointer;
	reg [15:0] tx_sent_pointer;
	reg [15:0] rx_read_pointer;
	reg cmd_done;
	reg issue;
	reg [`SOCKC_FLAG_COUNT-1:0] flag_set;
	reg [31:0] rdata;
	reg hit;
	wire [11:0] index;
	wire wr;
	wire [7:0] socket_event_flags;
	wire [3:0] proto;
	wire is_tcp;
	wire is_udp;
	wire connected;
	wire can_send;
	wire cmd_wr;
	reg mode_ok;
	reg [7:0] open_state;

	sockc_apb_slave #(
		.AW(AW)
	) u_apb (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_ce(i_ce),
		.i_psel(i_psel),
		.i_penable(i_penable),
		.i_pwrite(i_pwrite),
		.i_paddr(i_paddr),
		.i_rdata(rdata),
		.i_hit(hit),
		.o_index(index),
		.o_wr(wr),
		.o_prdata(o_prdata),
		.o_pready(o_pready),
		.o_pslverr(o_pslverr)
	);

	sockc_event_flags u_flags (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_ce(i_ce),
		.i_set(flag_set),
		.i_clr_wr(wr && (index == `SOCKC_IDX_FLAGS)),
		.i_clr_data(i_pwdata[7:0]),
		.o_flags(socket_event_flags)
	);

	// mode and state qualifiers used by the command decode
	assign proto = socket_protocol_mode[3:0];
	assign is_tcp = (proto == `SOCKC_MODE_TCP);
	assign is_udp = (proto == `SOCKC_MODE_UDP);
	assign connected = (socket_state == `SOCKC_ST_ESTABLISHED) || (socket_state == `SOCKC_ST_CLOSE_WAIT);
	assign can_send = (is_tcp && connected) || (socket_state == `SOCKC_ST_DATAGRAM) ||
		(socket_state == `SOCKC_ST_RAW_IP) || (socket_state == `SOCKC_ST_RAW_ETHERNET);
	// a new command is only taken while the previous one has cleared
	assign cmd_wr = wr && (index == `SOCKC_IDX_COMMAND) && (socket_command == `SOCKC_CMD_NONE);

	// state entered by open for each protocol mode
	always @*
	begin
		mode_ok = 1'b1;
		open_state = socket_state;
		case (proto)
			`SOCKC_MODE_TCP: open_state = `SOCKC_ST_TCP_INITIAL; // R18
			`SOCKC_MODE_UDP: open_state = `SOCKC_ST_DATAGRAM; // R18
			`SOCKC_MODE_RAW_IP: open_state = `SOCKC_ST_RAW_IP; // R18
			`SOCKC_MODE_RAW_ETHERNET:
			begin
				// raw ethernet exists on the first socket only
				mode_ok = (SOCKET_ID == 0); // R19
				open_state = `SOCKC_ST_RAW_ETHERNET; // R18
			end
			default: mode_ok = 1'b0; // R21
		endcase
	end

	// register map decode and read mux
	always @*
	begin
		hit = 1'b1;
		rdata = 32'h00000000;
		case (index)
			`SOCKC_IDX_MODE: rdata = {24'h000000, socket_protocol_mode};
			`SOCKC_IDX_COMMAND: rdata = {24'h000000, socket_command};
			`SOCKC_IDX_FLAGS: rdata = {24'h000000, socket_event_flags};
			`SOCKC_IDX_STATE: rdata = {24'h000000, socket_state};
			`SOCKC_IDX_TX_WR: rdata = {16'h0000, tx_write_pointer};
			`SOCKC_IDX_RX_RD: rdata = {16'h0000, rx_read_pointer};
			default: hit = 1'b0;
		endcase
	end

	// command sequencer: idle, decode one cycle, then wait on the engine if needed
	always @*
	begin
		next_phase = phase;
		next_state = socket_state;
		cmd_done = 1'b0;
		issue = 1'b0;
		flag_set = {`SOCKC_FLAG_COUNT{1'b0}};
		case (phase)
			PH_IDLE:
			begin
				if (socket_command != `SOCKC_CMD_NONE)
					next_phase = PH_EXEC;
				// peer-driven transitions happen only while no command runs
				if ((socket_state == `SOCKC_ST_LISTENING) && i_peer_conn)
				begin
					next_state = `SOCKC_ST_ESTABLISHED;
					flag_set[`SOCKC_FLAG_LINK_UP] = 1'b1; // R17
				end
				else if ((socket_state == `SOCKC_ST_ESTABLISHED) && i_peer_fin)
				begin
					next_state = `SOCKC_ST_CLOSE_WAIT;
					flag_set[`SOCKC_FLAG_LINK_DOWN] = 1'b1; // R16
				end
			end
			PH_EXEC:
			begin
				next_phase = PH_IDLE;
				cmd_done = 1'b1;
				case (socket_command)
					`SOCKC_CMD_OPEN:
						if (mode_ok)
							next_state = open_state; // R2
					`SOCKC_CMD_LISTEN:
						if (is_tcp && (socket_state == `SOCKC_ST_TCP_INITIAL))
							next_state = `SOCKC_ST_LISTENING; // R3
					`SOCKC_CMD_CONNECT:
						if (is_tcp && (socket_state == `SOCKC_ST_TCP_INITIAL))
						begin
							next_state = `SOCKC_ST_SYN_SENT; // R4
							issue = 1'b1;
							cmd_done = 1'b0;
							next_phase = PH_WAIT;
						end
					`SOCKC_CMD_TEARDOWN:
						if (is_tcp && connected)
						begin
							next_state = `SOCKC_ST_FIN_WAIT; // R5
							issue = 1'b1;
							cmd_done = 1'b0;
							next_phase = PH_WAIT;
						end
					`SOCKC_CMD_CLOSE:
						next_state = `SOCKC_ST_SHUT; // R6 R7
					`SOCKC_CMD_SEND:
						if (can_send)
						begin
							issue = 1'b1; // R8
							cmd_done = 1'b0;
							next_phase = PH_WAIT;
						end
					`SOCKC_CMD_SEND_MANUAL:
						if (is_udp && (socket_state == `SOCKC_ST_DATAGRAM))
						begin
							issue = 1'b1; // R9
							cmd_done = 1'b0;
							next_phase = PH_WAIT;
						end
					`SOCKC_CMD_KEEPALIVE:
						if (is_tcp && connected)
						begin
							issue = 1'b1; // R10
							cmd_done = 1'b0;
							next_phase = PH_WAIT;
						end
					`SOCKC_CMD_RECEIVE_DONE:
						if (socket_state != `SOCKC_ST_SHUT)
						begin
							issue = 1'b1; // R11
							if (i_rx_pending)
								flag_set[`SOCKC_FLAG_RECEIVE] = 1'b1; // R15
						end
					default: ; // R21
				endcase
			end
			PH_WAIT:
			begin
				if (i_eng_done || i_eng_fail)
				begin
					next_phase = PH_IDLE;
					cmd_done = 1'b1;
					if (i_eng_fail)
					begin
						// a failed tcp exchange leaves the socket shut
						flag_set[`SOCKC_FLAG_TIMEOUT] = 1'b1; // R4 R5 R10 R14
						if (is_tcp)
							next_state = `SOCKC_ST_SHUT;
					end
					else
					begin
						case (socket_command)
							`SOCKC_CMD_CONNECT:
							begin
								next_state = `SOCKC_ST_ESTABLISHED;
								flag_set[`SOCKC_FLAG_LINK_UP] = 1'b1; // R17
							end
							`SOCKC_CMD_TEARDOWN:
							begin
								next_state = `SOCKC_ST_SHUT;
								flag_set[`SOCKC_FLAG_LINK_DOWN] = 1'b1; // R16
							end
							`SOCKC_CMD_KEEPALIVE: ;
							default: flag_set[`SOCKC_FLAG_TX_DONE] = 1'b1; // R13
						endcase
					end
				end
			end
			default: next_phase = PH_IDLE;
		endcase
		if (i_rx_arrived)
			flag_set[`SOCKC_FLAG_RECEIVE] = 1'b1; // R15
	end

	// sequencer state, socket state and the command byte
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			phase <= PH_IDLE;
			socket_state <= `SOCKC_ST_SHUT;
			socket_command <= `SOCKC_RST_BYTE;
		end
		else if (i_ce)
		begin
			phase <= next_phase;
			socket_state <= next_state;
			if (cmd_done)
				socket_command <= `SOCKC_CMD_NONE; // R1 R21
			else if (cmd_wr)
				socket_command <= i_pwdata[7:0];
		end
	end

	// software-written configuration and pointers
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			socket_protocol_mode <= `SOCKC_RST_BYTE;
			tx_write_pointer <= `SOCKC_RST_PTR;
			rx_read_pointer <= `SOCKC_RST_PTR;
		end
		else if (i_ce && wr)
		begin
			if (index == `SOCKC_IDX_MODE)
				socket_protocol_mode <= i_pwdata[7:0] & `SOCKC_MODE_WMASK;
			if (index == `SOCKC_IDX_TX_WR)
				tx_write_pointer <= i_pwdata[15:0];
			if (index == `SOCKC_IDX_RX_RD)
				rx_read_pointer <= i_pwdata[15:0];
		end
	end

	// engine request; send length is the pointer advance since the previous send, keep-alive length is one
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_eng_req <= 1'b0;
			o_eng_op <= `SOCKC_CMD_NONE;
			o_tx_start <= `SOCKC_RST_PTR;
			o_tx_len <= `SOCKC_RST_PTR;
			o_use_manual_hw <= 1'b0;
			o_rx_rd_ptr <= `SOCKC_RST_PTR;
			tx_sent_pointer <= `SOCKC_RST_PTR;
		end
		else if (i_ce)
		begin
			o_eng_req <= issue;
			if (issue)
			begin
				o_eng_op <= socket_command;
				o_use_manual_hw <= (socket_command == `SOCKC_CMD_SEND_MANUAL); // R9
				o_rx_rd_ptr <= rx_read_pointer; // R11
				if ((socket_command == `SOCKC_CMD_SEND) || (socket_command == `SOCKC_CMD_SEND_MANUAL))
				begin
					// wraps modulo 2^16, matching the buffer pointer width
					o_tx_start <= tx_sent_pointer;
					o_tx_len <= tx_write_pointer - tx_sent_pointer; // R8
					tx_sent_pointer <= tx_write_pointer;
				end
				else if (socket_command == `SOCKC_CMD_KEEPALIVE)
					o_tx_len <= 16'h0001; // R10
			end
		end
	end
endmodule // sockc_top

// *** tb/sockc_asserts.sv ***
// checker for the socket command block, watching only the top-level ports
// assumes ce is high in the bench and the default address width of 16 bits
`timescale 1ns/1ns
module sockc_asserts (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [15:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_eng_req,
	input wire logic [7:0] o_eng_op,
	input wire logic [15:0] o_tx_start,
	input wire logic [15:0] o_tx_len,
	input wire logic o_use_manual_hw,
	input wire logic [15:0] o_rx_rd_ptr,
	input wire logic i_eng_done,
	input wire logic i_eng_fail,
	input wire logic i_peer_conn,
	input wire logic i_peer_fin,
	input wire logic i_rx_arrived,
	input wire logic i_rx_pending
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	// one request per command that needs the engine, never stretched
	req_pulse_a:
		assert property (o_eng_req |=> !o_eng_req) else $error("engine request held too long");
	close_silent_a:
		assert property (o_eng_req |-> o_eng_op != 8'h10) else $error("close reached the engine");
	engine_ops_a:
		assert property (o_eng_req |-> o_eng_op inside {8'h04, 8'h08, 8'h20, 8'h21, 8'h22, 8'h40})
			else $error("engine request with bad op");
	keep_len_a:
		assert property (o_eng_req && o_eng_op == 8'h22 |-> o_tx_len == 16'h0001) else $error("probe length not one");
	manual_hw_a:
		assert property (o_eng_req |-> o_use_manual_hw == (o_eng_op == 8'h21)) else $error("manual address flag wrong");
	op_hold_a:
		assert property (o_eng_req ##1 !o_eng_req |-> $stable(o_eng_op)) else $error("op changed without request");
	// zero wait states, and errors only ride on ready
	ready_a:
		assert property (i_psel && i_penable && i_ce |-> o_pready) else $error("ready missing in access");
	err_ready_a:
		assert property (o_pslverr |-> o_pready) else $error("error without ready");
	flags_upper_a:
		assert property (i_psel && i_penable && !i_pwrite && i_paddr == 16'h1008 |-> o_prdata[31:5] == 27'h0)
			else $error("flag upper bits not zero");
	state_code_a:
		assert property (i_psel && i_penable && !i_pwrite && i_paddr == 16'h100C
			|-> o_prdata[7:0] inside {8'h00, 8'h13, 8'h14, 8'h15, 8'h17, 8'h18, 8'h1C, 8'h22, 8'h32, 8'h42})
			else $error("unknown state code read");
endmodule // sockc_asserts
bind sockc_top sockc_asserts u_sockc_asserts (.*);

// *** tb/sockc_top_tb.sv ***
// bench for the socket command block: apb tasks and command sequences
// assumes a three-cycle engine answer made here; receive-done gets none
`timescale 1ns/1ns
`include "sockc_consts.vh"
module sockc_top_tb;
	logic i_clk = 0, i_nrst = 0, i_ce = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
	logic [15:0] i_paddr = 16'h0000, o_tx_start, o_tx_len, o_rx_rd_ptr, len_seen;
	logic [31:0] i_pwdata = 32'h0, o_prdata, rd, prdata_s1, rd_s1;
	logic o_pready, o_pslverr, o_eng_req, o_use_manual_hw, slverr, man_seen, fail_next = 0;
	logic [7:0] o_eng_op;
	logic i_eng_done = 0, i_eng_fail = 0, i_peer_conn = 0, i_peer_fin = 0, i_rx_arrived = 0, i_rx_pending = 0;
	logic [2:0] eng_cnt = 3'h0;
	logic [7:0] st [4] = '{8'h13, 8'h22, 8'h32, 8'h42};
	int err_count = 0, n_checks = 0, cyc = 0;
	sockc_top u_sockc_top (.*);
	// second socket on the same bus follows every step, but must refuse raw ethernet
	sockc_top #(
		.SOCKET_ID(1)
	) u_sockc_top_s1 (
		.*,
		.o_prdata(prdata_s1),
		.o_pready(),
		.o_pslverr(),
		.o_eng_req(),
		.o_eng_op(),
		.o_tx_start(),
		.o_tx_len(),
		.o_use_manual_hw(),
		.o_rx_rd_ptr()
	);
	always #5 i_clk = ~i_clk;
	// engine stand-in, request capture and hang guard
	always @(posedge i_clk)
	begin
		cyc <= cyc + 1;
		i_eng_done <= 1'b0;
		i_eng_fail <= 1'b0;
		if (o_eng_req)
		begin
			len_seen <= o_tx_len;
			man_seen <= o_use_manual_hw;
			eng_cnt <= (o_eng_op == `SOCKC_CMD_RECEIVE_DONE) ? 3'h0 : 3'h3;
		end
		else if (eng_cnt != 3'h0)
		begin
			eng_cnt <= eng_cnt - 3'h1;
			i_eng_done <= (eng_cnt == 3'h1) && !fail_next;
			i_eng_fail <= (eng_cnt == 3'h1) && fail_next;
		end
		if (cyc == 20000)
		begin
			err_count++;
			wrap_up();
		end
	end
	function automatic logic [15:0] ad(input logic [11:0] i);
		return {2'b00, i, 2'b00};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer; an idle edge first keeps drives of one step apart
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		do @(posedge i_clk); while (o_pready !== 1'b1);
		rd = o_prdata;
		slverr = o_pslverr;
		rd_s1 = prdata_s1;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] i, input logic [31:0] d);
		apb(1'b1, ad(i), d);
	endtask
	task automatic rc(input logic [11:0] i, input logic [31:0] e);
		apb(1'b0, ad(i), 32'h0);
		chk(rd, e);
	endtask
	// write a command, then poll until the byte clears
	task automatic cmd(input logic [7:0] c);
		int n;
		n = 0;
		wr(`SOCKC_IDX_COMMAND, {24'h0, c});
		do
		begin
			apb(1'b0, ad(`SOCKC_IDX_COMMAND), 32'h0);
			n++;
		end
		while (rd !== 32'h0 && n < 40);
		chk(rd, 32'h0);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge i_clk);
		i_nrst <= 1'b1;
		rc(`SOCKC_IDX_FLAGS, 32'h0);
		rc(`SOCKC_IDX_STATE, 32'h0);
		apb(1'b0, 16'h1FF0, 32'h0);
		chk(slverr, 1'b1);
		$display("test reset done");
		// every mode opens to its own state, closed again each time
		for (int m = 0; m < 4; m++)
		begin
			wr(`SOCKC_IDX_MODE, m + 1);
			cmd(`SOCKC_CMD_OPEN);
			rc(`SOCKC_IDX_STATE, st[m]);
			chk(rd_s1, (m == 3) ? 32'h0 : st[m]);
			if (m == 1)
			begin
				wr(`SOCKC_IDX_TX_WR, 32'h4);
				cmd(`SOCKC_CMD_SEND_MANUAL);
				chk(man_seen, 1'b1);
				chk(len_seen, 16'h0004);
				rc(`SOCKC_IDX_FLAGS, 32'h10);
				wr(`SOCKC_IDX_FLAGS, 32'hFF);
				rc(`SOCKC_IDX_FLAGS, 32'h0);
			end
			cmd(`SOCKC_CMD_CLOSE);
			rc(`SOCKC_IDX_STATE, 32'h0);
		end
		cmd(`SOCKC_CMD_LISTEN);
		cmd(8'h03);
		rc(`SOCKC_IDX_STATE, 32'h0);
		$display("test modes done");
		// server side: listen, peer connects, flags clear bit by bit
		wr(`SOCKC_IDX_MODE, 32'h1);
		cmd(`SOCKC_CMD_OPEN);
		cmd(`SOCKC_CMD_LISTEN);
		rc(`SOCKC_IDX_STATE, 32'h14);
		i_peer_conn <= 1'b1;
		@(posedge i_clk);
		i_peer_conn <= 1'b0;
		rc(`SOCKC_IDX_STATE, 32'h17);
		rc(`SOCKC_IDX_FLAGS, 32'h01);
		wr(`SOCKC_IDX_FLAGS, 32'hE2);
		rc(`SOCKC_IDX_FLAGS, 32'h01);
		wr(`SOCKC_IDX_FLAGS, 32'h01);
		rc(`SOCKC_IDX_FLAGS, 32'h0);
		wr(`SOCKC_IDX_TX_WR, 32'h14);
		cmd(`SOCKC_CMD_SEND);
		chk(len_seen, 16'h0010);
		chk(o_tx_start, 16'h0004);
		chk(man_seen, 1'b0);
		rc(`SOCKC_IDX_FLAGS, 32'h10);
		wr(`SOCKC_IDX_TX_WR, 32'h3);
		cmd(`SOCKC_CMD_SEND);
		chk(len_seen, 16'hFFEF);
		chk(o_tx_start, 16'h0014);
		cmd(`SOCKC_CMD_KEEPALIVE);
		chk(len_seen, 16'h0001);
		wr(`SOCKC_IDX_FLAGS, 32'hFF);
		i_peer_fin <= 1'b1;
		@(posedge i_clk);
		i_peer_fin <= 1'b0;
		rc(`SOCKC_IDX_FLAGS, 32'h02);
		wr(`SOCKC_IDX_FLAGS, 32'h02);
		cmd(`SOCKC_CMD_TEARDOWN);
		rc(`SOCKC_IDX_FLAGS, 32'h02);
		rc(`SOCKC_IDX_STATE, 32'h0);
		wr(`SOCKC_IDX_FLAGS, 32'hFF);
		$display("test server done");
		// client side: refused connect, good connect, close, failed probe
		cmd(`SOCKC_CMD_OPEN);
		fail_next <= 1'b1;
		cmd(`SOCKC_CMD_CONNECT);
		rc(`SOCKC_IDX_FLAGS, 32'h08);
		rc(`SOCKC_IDX_STATE, 32'h0);
		fail_next <= 1'b0;
		wr(`SOCKC_IDX_FLAGS, 32'h08);
		cmd(`SOCKC_CMD_OPEN);
		cmd(`SOCKC_CMD_CONNECT);
		rc(`SOCKC_IDX_STATE, 32'h17);
		cmd(`SOCKC_CMD_CLOSE);
		rc(`SOCKC_IDX_STATE, 32'h0);
		rc(`SOCKC_IDX_FLAGS, 32'h01);
		wr(`SOCKC_IDX_FLAGS, 32'h01);
		cmd(`SOCKC_CMD_OPEN);
		cmd(`SOCKC_CMD_CONNECT);
		wr(`SOCKC_IDX_FLAGS, 32'h01);
		fail_next <= 1'b1;
		cmd(`SOCKC_CMD_KEEPALIVE);
		rc(`SOCKC_IDX_FLAGS, 32'h08);
		fail_next <= 1'b0;
		wr(`SOCKC_IDX_FLAGS, 32'h08);
		$display("test client done");
		// receive path: pending data re-raises the flag
		wr(`SOCKC_IDX_MODE, 32'h2);
		cmd(`SOCKC_CMD_OPEN);
		wr(`SOCKC_IDX_RX_RD, 32'h40);
		i_rx_pending <= 1'b1;
		cmd(`SOCKC_CMD_RECEIVE_DONE);
		chk(o_rx_rd_ptr, 16'h0040);
		rc(`SOCKC_IDX_FLAGS, 32'h04);
		i_rx_pending <= 1'b0;
		wr(`SOCKC_IDX_FLAGS, 32'h04);
		rc(`SOCKC_IDX_FLAGS, 32'h0);
		i_rx_arrived <= 1'b1;
		@(posedge i_clk);
		i_rx_arrived <= 1'b0;
		rc(`SOCKC_IDX_FLAGS, 32'h04);
		$display("test receive done");
		wrap_up();
	end
endmodule // sockc_top_tb
